// ### core/crf_match.sv
/*
  One acceptance filter: masked compare of a frame against code registers.
  Assumes frame and registers are stable on pclk; purely combinational.
*/
`timescale 1ns/1ps
module crf_match (
  input wire crf_pkg::crf_frame_t frame,
  input wire logic [31:0] mask,
  input wire logic [31:0] code,
  input wire logic [15:0] dmask,
  input wire logic [15:0] dcode,
  output logic hit
);
  logic [31:0] fword;
  logic [15:0] dword;
  always_comb begin
    fword = crf_pkg::ZERO32;
    if (frame.ide) begin
      fword[31:crf_pkg::EXT_ID_LO] = frame.id;
    end else begin
      fword[31:crf_pkg::STD_ID_LO] = frame.id[10:0];
    end
    fword[crf_pkg::F_IDE] = frame.ide;
    fword[crf_pkg::F_RTR] = frame.rtr;
    // Remote frames carry no data, so their data bits compare as zero
    dword = frame.rtr ? 16'h0000 : frame.data[63:48];
  end
  // Masked bits drop out; unmasked mismatch rejects
  assign hit = ((((fword ^ code) & ~mask) == crf_pkg::ZERO32) &&
                (((dword ^ dcode) & ~dmask) == 16'h0000));
endmodule

// ### core/crf_top.sv
/*
  CAN receive side: sixteen filtered buffers, linking, auto answer of remote frames.
  Assumes a framer handing over one frame at a time by valid/ready, and a transmitter
  that takes an auto answer by valid/ready. APB slave for all registers.
*/
`timescale 1ns/1ps
module crf_top #(
  parameter int NBUF = crf_pkg::NBUF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire crf_pkg::crf_frame_t rx_frame,
  output logic rx_ready,
  output logic tx_valid,
  output crf_pkg::crf_reply_t tx_reply,
  input wire logic tx_ready,
  output logic receive_done_irq,
  output logic receive_overrun_irq
);
  typedef enum {ST_IDLE, ST_SEARCH, ST_STORE} crf_state_t;

  crf_state_t state_ff;
  crf_pkg::crf_frame_t frame_ff;
  logic [crf_pkg::IDXW-1:0] idx_ff;
  logic [crf_pkg::IDXW-1:0] tgt_ff;
  logic [NBUF-1:0] message_available_flag_ff, pend_ff, en_ff, ans_ff, ie_ff, link_ff;
  logic [31:0] mask_ff [NBUF];
  logic [31:0] code_ff [NBUF];
  logic [15:0] dmask_ff [NBUF];
  logic [15:0] dcode_ff [NBUF];
  logic [28:0] id_ff [NBUF];
  logic ide_ff [NBUF];
  logic rtr_ff [NBUF];
  logic [3:0] dlc_ff [NBUF];
  logic [63:0] data_ff [NBUF];
  logic [NBUF-1:0] hit;
  logic [31:0] int_sr_ff;
  logic [crf_pkg::IDXW-1:0] ans_idx_ff;
  logic done_set, ovr_set;
  logic store_now;
  logic [NBUF-1:0] sent_clr;

  genvar g;
  generate
    for (g = 0; g < NBUF; g++) begin : gen_flt
      crf_match u_match (
        .frame(frame_ff),
        .mask(mask_ff[g]),
        .code(code_ff[g]),
        .dmask(dmask_ff[g]),
        .dcode(dcode_ff[g]),
        .hit(hit[g])
      );
    end
  endgenerate

  // APB decode
  logic wr_en, rd_en;
  logic [crf_pkg::IDXW-1:0] a_buf;
  logic [2:0] a_word;
  logic a_isbuf, a_isint;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign a_buf = paddr[crf_pkg::BUF_SHIFT+crf_pkg::IDXW-1:crf_pkg::BUF_SHIFT];
  assign a_word = paddr[4:2];
  assign a_isbuf = (paddr < crf_pkg::OFS_INT_SR) && (paddr[1:0] == 2'b00);
  assign a_isint = (paddr == crf_pkg::OFS_INT_SR);

  // Search engine: one buffer per cycle, upward from buffer 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      frame_ff <= '0;
      idx_ff <= '0;
      tgt_ff <= '0;
      rx_ready <= 1'b0;
    end else begin
      rx_ready <= (state_ff == ST_IDLE);
      case (state_ff)
        ST_IDLE: begin
          if (rx_valid && rx_ready) begin
            frame_ff <= rx_frame;
            idx_ff <= '0;
            rx_ready <= 1'b0;
            state_ff <= ST_SEARCH;
          end
        end
        ST_SEARCH: begin
          if (en_ff[idx_ff] && hit[idx_ff] &&
              (!message_available_flag_ff[idx_ff] || !link_ff[idx_ff])) begin
            tgt_ff <= idx_ff;
            state_ff <= ST_STORE;
          end else if (idx_ff == crf_pkg::IDXW'(NBUF - 1)) begin
            state_ff <= ST_IDLE;
          end else begin
            idx_ff <= idx_ff + 1'b1;
          end
        end
        ST_STORE: begin
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Overrun: full unlinked target, or linked chain ran out of buffers
  logic chain_seen_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_seen_ff <= 1'b0;
    end else if (state_ff == ST_IDLE) begin
      chain_seen_ff <= 1'b0;
    end else if (state_ff == ST_SEARCH && en_ff[idx_ff] && hit[idx_ff] &&
                 message_available_flag_ff[idx_ff] && link_ff[idx_ff]) begin
      chain_seen_ff <= 1'b1;
    end
  end

  assign store_now = (state_ff == ST_STORE) && !message_available_flag_ff[tgt_ff];
  assign ovr_set = ((state_ff == ST_STORE) && message_available_flag_ff[tgt_ff]) ||
                   ((state_ff == ST_SEARCH) && chain_seen_ff &&
                    !(en_ff[idx_ff] && hit[idx_ff]) &&
                    (idx_ff == crf_pkg::IDXW'(NBUF - 1))) ||
                   ((state_ff == ST_SEARCH) && (idx_ff == crf_pkg::IDXW'(NBUF - 1)) &&
                    en_ff[idx_ff] && hit[idx_ff] && message_available_flag_ff[idx_ff] &&
                    link_ff[idx_ff]);
  assign done_set = store_now && ie_ff[tgt_ff];

  // Message contents: written by the store or by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NBUF; i++) begin
        id_ff[i] <= '0;
        ide_ff[i] <= 1'b0;
        rtr_ff[i] <= 1'b0;
        dlc_ff[i] <= '0;
        data_ff[i] <= '0;
      end
    end else if (store_now) begin
      id_ff[tgt_ff] <= frame_ff.id;
      ide_ff[tgt_ff] <= frame_ff.ide;
      rtr_ff[tgt_ff] <= frame_ff.rtr;
      dlc_ff[tgt_ff] <= frame_ff.dlc;
      // A remote request keeps the buffer's answer data
      if (!frame_ff.rtr) begin
        data_ff[tgt_ff] <= frame_ff.data;
      end
    end else if (wr_en && a_isbuf) begin
      if (a_word == crf_pkg::W_ID) begin
        id_ff[a_buf] <= pwdata[31:crf_pkg::EXT_ID_LO];
      end else if (a_word == crf_pkg::W_DH) begin
        data_ff[a_buf][63:32] <= pwdata;
      end else if (a_word == crf_pkg::W_DL) begin
        data_ff[a_buf][31:0] <= pwdata;
      end else if (a_word == crf_pkg::W_CMD) begin
        ide_ff[a_buf] <= pwdata[crf_pkg::B_IDE];
        dlc_ff[a_buf] <= pwdata[crf_pkg::B_DLC_LO+3:crf_pkg::B_DLC_LO];
      end
    end
  end

  // Filter registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NBUF; i++) begin
        mask_ff[i] <= '0;
        code_ff[i] <= '0;
        dmask_ff[i] <= '0;
        dcode_ff[i] <= '0;
      end
    end else if (wr_en && a_isbuf) begin
      if (a_word == crf_pkg::W_MASK) begin
        mask_ff[a_buf] <= pwdata;
      end else if (a_word == crf_pkg::W_CODE) begin
        code_ff[a_buf] <= pwdata;
      end else if (a_word == crf_pkg::W_DMASK) begin
        dmask_ff[a_buf] <= pwdata[15:0];
      end else if (a_word == crf_pkg::W_DCODE) begin
        dcode_ff[a_buf] <= pwdata[15:0];
      end
    end
  end

  // Command flags; hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      message_available_flag_ff <= '0;
      pend_ff <= '0;
      en_ff <= '0;
      ans_ff <= '0;
      ie_ff <= '0;
      link_ff <= '0;
    end else begin
      for (int i = 0; i < NBUF; i++) begin
        if (wr_en && a_isbuf && a_word == crf_pkg::W_CMD &&
            a_buf == crf_pkg::IDXW'(i)) begin
          en_ff[i] <= pwdata[crf_pkg::B_BUF_EN];
          ans_ff[i] <= pwdata[crf_pkg::B_ANSWER];
          ie_ff[i] <= pwdata[crf_pkg::B_RX_IE];
          link_ff[i] <= pwdata[crf_pkg::B_LINK];
          if (!pwdata[crf_pkg::B_MESSAGE_AVAILABLE_FLAG]) begin
            message_available_flag_ff[i] <= 1'b0;
          end
          if (pwdata[crf_pkg::B_CANCEL] || !pwdata[crf_pkg::B_BUF_EN]) begin
            pend_ff[i] <= 1'b0;
          end
        end
        if (sent_clr[i]) begin
          pend_ff[i] <= 1'b0;
        end
        if (store_now && tgt_ff == crf_pkg::IDXW'(i)) begin
          message_available_flag_ff[i] <= 1'b1;
          if (frame_ff.rtr && ans_ff[i]) begin
            pend_ff[i] <= 1'b1;
          end
        end
      end
    end
  end

  // Auto answer: lowest pending buffer is offered to the transmitter
  logic [crf_pkg::IDXW-1:0] pick;
  logic pick_ok;
  always_comb begin
    pick = '0;
    pick_ok = 1'b0;
    for (int i = NBUF - 1; i >= 0; i--) begin
      if (pend_ff[i]) begin
        pick = crf_pkg::IDXW'(i);
        pick_ok = 1'b1;
      end
    end
  end
  always_comb begin
    sent_clr = '0;
    if (tx_valid && tx_ready) begin
      sent_clr[ans_idx_ff] = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid <= 1'b0;
      tx_reply <= '0;
      ans_idx_ff <= '0;
    end else if (tx_valid) begin
      // Withdraw if cancelled or disabled while offered
      if (tx_ready || !pend_ff[ans_idx_ff]) begin
        tx_valid <= 1'b0;
      end
    end else if (pick_ok && !sent_clr[pick]) begin
      tx_valid <= 1'b1;
      ans_idx_ff <= pick;
      tx_reply.id <= id_ff[pick];
      tx_reply.ide <= ide_ff[pick];
      tx_reply.dlc <= dlc_ff[pick];
      tx_reply.data <= data_ff[pick];
    end
  end

  // Interrupt status: write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_sr_ff <= '0;
      receive_done_irq <= 1'b0;
      receive_overrun_irq <= 1'b0;
    end else begin
      if (wr_en && a_isint) begin
        int_sr_ff[crf_pkg::IRQ_DONE] <= int_sr_ff[crf_pkg::IRQ_DONE] &
                                        ~pwdata[crf_pkg::IRQ_DONE];
        int_sr_ff[crf_pkg::IRQ_OVR] <= int_sr_ff[crf_pkg::IRQ_OVR] &
                                       ~pwdata[crf_pkg::IRQ_OVR];
      end
      if (done_set) begin
        int_sr_ff[crf_pkg::IRQ_DONE] <= 1'b1;
      end
      if (ovr_set) begin
        int_sr_ff[crf_pkg::IRQ_OVR] <= 1'b1;
      end
      receive_done_irq <= int_sr_ff[crf_pkg::IRQ_DONE];
      receive_overrun_irq <= int_sr_ff[crf_pkg::IRQ_OVR];
    end
  end

  // Read mux, captured in setup phase; answer in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !a_isbuf && !a_isint;
      if (rd_en) begin
        prdata <= '0;
        if (a_isint) begin
          prdata <= int_sr_ff;
        end else if (a_isbuf && a_word == crf_pkg::W_CMD) begin
          prdata[crf_pkg::B_RTR] <= rtr_ff[a_buf];
          prdata[crf_pkg::B_IDE] <= ide_ff[a_buf];
          prdata[crf_pkg::B_DLC_LO+3:crf_pkg::B_DLC_LO] <= dlc_ff[a_buf];
          prdata[crf_pkg::B_LINK] <= link_ff[a_buf];
          prdata[crf_pkg::B_RX_IE] <= ie_ff[a_buf];
          prdata[crf_pkg::B_ANSWER] <= ans_ff[a_buf];
          prdata[crf_pkg::B_BUF_EN] <= en_ff[a_buf];
          prdata[crf_pkg::B_PEND] <= pend_ff[a_buf];
          prdata[crf_pkg::B_MESSAGE_AVAILABLE_FLAG] <= message_available_flag_ff[a_buf];
        end else if (a_isbuf && a_word == crf_pkg::W_ID) begin
          prdata[31:crf_pkg::EXT_ID_LO] <= id_ff[a_buf];
        end else if (a_isbuf && a_word == crf_pkg::W_DH) begin
          prdata <= data_ff[a_buf][63:32];
        end else if (a_isbuf && a_word == crf_pkg::W_DL) begin
          prdata <= data_ff[a_buf][31:0];
        end else if (a_isbuf && a_word == crf_pkg::W_MASK) begin
          prdata <= mask_ff[a_buf];
        end else if (a_isbuf && a_word == crf_pkg::W_CODE) begin
          prdata <= code_ff[a_buf];
        end else if (a_isbuf && a_word == crf_pkg::W_DMASK) begin
          prdata[15:0] <= dmask_ff[a_buf];
        end else if (a_isbuf) begin
          prdata[15:0] <= dcode_ff[a_buf];
        end
      end
    end
  end
endmodule

// ### shared/crf_pkg.sv
/*
  Constants, register map and carrier types for the CAN receive filter block.
  Assumes an APB master on pclk and a CAN framer that hands over whole frames.
*/
package crf_pkg;
  localparam int NBUF = 16;
  localparam int IDXW = 4;
  // Byte offsets: per buffer a 32-byte stride of eight words
  localparam logic [11:0] OFS_BUF_BASE = 12'h000;
  localparam int BUF_SHIFT = 5;
  localparam logic [2:0] W_CMD = 3'h0;
  localparam logic [2:0] W_ID = 3'h1;
  localparam logic [2:0] W_DH = 3'h2;
  localparam logic [2:0] W_DL = 3'h3;
  localparam logic [2:0] W_MASK = 3'h4;
  localparam logic [2:0] W_CODE = 3'h5;
  localparam logic [2:0] W_DMASK = 3'h6;
  localparam logic [2:0] W_DCODE = 3'h7;
  localparam logic [11:0] OFS_INT_SR = 12'h200;
  // Command bits
  localparam int B_MESSAGE_AVAILABLE_FLAG = 0;
  localparam int B_PEND = 1;
  localparam int B_CANCEL = 2;
  localparam int B_BUF_EN = 3;
  localparam int B_ANSWER = 4;
  localparam int B_RX_IE = 5;
  localparam int B_LINK = 6;
  localparam int B_IDE = 20;
  localparam int B_RTR = 21;
  localparam int B_DLC_LO = 16;
  // Filter word layout: ID[31:3], IDE bit 2, RTR bit 1
  localparam int F_IDE = 2;
  localparam int F_RTR = 1;
  localparam int STD_ID_LO = 21;
  localparam int EXT_ID_LO = 3;
  // Interrupt status bits
  localparam int IRQ_DONE = 12;
  localparam int IRQ_OVR = 10;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  typedef struct packed {
    logic [28:0] id;
    logic ide;
    logic rtr;
    logic [3:0] dlc;
    logic [63:0] data;
  } crf_frame_t;

  typedef struct packed {
    logic [28:0] id;
    logic ide;
    logic [3:0] dlc;
    logic [63:0] data;
  } crf_reply_t;
endpackage

// ### test/crf_node.sv
/*
  Far-side node model: offers whole frames and takes auto answers.
  Assumes send is called just after a rising pclk edge.
*/
`timescale 1ns/1ps
module crf_node (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall,
  output logic rx_valid,
  output crf_pkg::crf_frame_t rx_frame,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire crf_pkg::crf_reply_t tx_reply,
  output logic tx_ready
);
  crf_pkg::crf_reply_t last_ff;
  int taken_ff;
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
  end
  function automatic crf_pkg::crf_frame_t mk(input logic [28:0] id, input logic ide,
    input logic rtr, input logic [63:0] d);
    return '{id, ide, rtr, 4'h8, rtr ? 64'h0 : d};
  endfunction
  task automatic send(input crf_pkg::crf_frame_t f);
    // Waits without limit; the bench cycle ceiling ends a hang
    rx_valid <= 1'b1;
    rx_frame <= f;
    do begin
      @(posedge pclk);
    end while (!rx_ready);
    rx_valid <= 1'b0;
    // Inverted, so a late sample cannot pass for the frame
    rx_frame <= ~f;
    do begin
      @(posedge pclk);
    end while (!rx_ready);
    repeat (3) @(posedge pclk);
  endtask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      taken_ff <= 0;
    end else begin
      if (tx_valid && tx_ready) begin
        taken_ff <= taken_ff + 1;
        last_ff <= tx_reply;
      end
      tx_ready <= !stall;
    end
  end
endmodule

// ### test/crf_top_monitor.sv
/*
  Checker for crf_top: APB beats, frame intake and auto answer timing.
  Assumes it is bound to crf_top and sees its ports only.
*/
`timescale 1ns/1ps
module crf_top_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire crf_pkg::crf_reply_t tx_reply,
  input wire logic tx_ready,
  input wire logic receive_done_irq,
  input wire logic receive_overrun_irq
);
  // Saturates so an old frame never excuses a late event
  logic [5:0] age_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_ff <= 6'h3f;
    end else if (rx_valid && rx_ready) begin
      age_ff <= 6'h00;
    end else if (age_ff != 6'h3f) begin
      age_ff <= age_ff + 6'h01;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  reset_quiet_a: assert property ($rose(presetn) |-> !rx_ready && !tx_valid && !pready)
    else $error("output active at reset release");
  apb_no_wait_a: assert property (psel && !penable ##1 psel && penable |-> pready)
    else $error("access phase without ready");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error flag outside ready");
  search_bound_a: assert property (rx_valid && rx_ready |=> !rx_ready ##[1:30] rx_ready)
    else $error("frame search overran");
  done_cause_a: assert property ($rose(receive_done_irq) |-> age_ff <= 6'h1e)
    else $error("receive done without frame");
  overrun_cause_a: assert property ($rose(receive_overrun_irq) |-> age_ff <= 6'h1e)
    else $error("overrun without frame");
  answer_cause_a: assert property ($rose(tx_valid) |-> age_ff <= 6'h1e)
    else $error("answer without remote frame");
  answer_hold_a: assert property (tx_valid && !tx_ready && rx_ready && $past(rx_ready)
    && !(psel && pwrite) && !$past(psel && pwrite) |=> tx_valid && $stable(tx_reply))
    else $error("answer offer dropped or changed");
endmodule

bind crf_top crf_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_reply(tx_reply),
  .tx_ready(tx_ready), .receive_done_irq(receive_done_irq),
  .receive_overrun_irq(receive_overrun_irq));

// ### test/crf_top_test.sv
/*
  Bench for crf_top: APB master tasks, frames through crf_node, compares.
  Assumes crf_top_monitor is bound from its own file.
*/
`timescale 1ns/1ps
module crf_top_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall, last_err;
  logic rx_valid, rx_ready, tx_valid, tx_ready, receive_done_irq, receive_overrun_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  crf_pkg::crf_frame_t rx_frame;
  crf_pkg::crf_reply_t tx_reply;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0;
  // Compares ID[31:21], IDE and RTR only
  localparam logic [31:0] std_mask = 32'h001f_fff9;
  localparam logic [2:0] wc = crf_pkg::W_CMD;
  localparam logic [2:0] wd = crf_pkg::W_DH;
  crf_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_reply(tx_reply), .tx_ready(tx_ready),
    .receive_done_irq(receive_done_irq), .receive_overrun_irq(receive_overrun_irq));
  crf_node node (.pclk(pclk), .presetn(presetn), .stall(stall), .rx_valid(rx_valid),
    .rx_frame(rx_frame), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_reply(tx_reply),
    .tx_ready(tx_ready));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait limit here; the cycle ceiling ends a hang
    do begin
      @(posedge pclk);
    end while (!pready);
    rdata = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [11:0] ra(input int b, input logic [2:0] w);
    return 12'(b * 32) | {7'h00, w, 2'b00};
  endfunction
  task automatic rd(input int b, input logic [2:0] w, input logic [31:0] m, e);
    apb(1'b0, ra(b, w), 32'h0);
    chk(rdata & m, e);
  endtask
  task automatic st(input logic [31:0] e);
    apb(1'b0, crf_pkg::OFS_INT_SR, 32'h0);
    chk(rdata & 32'h0000_1400, e);
    apb(1'b1, crf_pkg::OFS_INT_SR, 32'h0000_1400);
  endtask
  task automatic cfg(input int b, input logic [31:0] c, m, k, input logic [15:0] dm, dc);
    apb(1'b1, ra(b, crf_pkg::W_MASK), m);
    apb(1'b1, ra(b, crf_pkg::W_CODE), k);
    apb(1'b1, ra(b, crf_pkg::W_DMASK), {16'h0000, dm});
    apb(1'b1, ra(b, crf_pkg::W_DCODE), {16'h0000, dc});
    apb(1'b1, ra(b, wc), c);
  endtask
  task automatic fr(input logic [28:0] id, input logic ide, rtr, input logic [63:0] d);
    node.send(node.mk(id, ide, rtr, d));
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    stall = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    cfg(0, 32'h0000_0028, std_mask, 32'h2460_0000, 16'hffff, 16'h0000);
    fr(29'h123, 1'b0, 1'b0, 64'h1122_3344_5566_7788);
    rd(0, wc, 32'h1, 32'h1);
    rd(0, crf_pkg::W_ID, 32'hffff_fff8, 32'h0000_0918);
    rd(0, wd, 32'hffff_ffff, 32'h1122_3344);
    chk({31'h0, receive_done_irq}, 32'h1);
    st(32'h0000_1000);
    fr(29'h122, 1'b0, 1'b0, 64'h0);
    st(32'h0000_0000);
    $display("store test done");
    cfg(1, 32'h0000_0028, 32'h601f_fff9, 32'h3040_0000, 16'h063f, 16'h0180);
    fr(29'h082, 1'b0, 1'b0, 64'h07bf_0000_0000_0000);
    rd(1, wc, 32'h1, 32'h1);
    fr(29'h182, 1'b0, 1'b0, 64'h01c0_0000_0000_0000);
    st(32'h0000_1000);
    $display("filter test done");
    cfg(2, 32'h0000_0048, std_mask, 32'h4000_0000, 16'hffff, 16'h0000);
    cfg(3, 32'h0000_0008, std_mask, 32'h4000_0000, 16'hffff, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      fr(29'h200, 1'b0, 1'b0, {32'(i), 32'h0});
    end
    rd(2, wd, 32'hffff_ffff, 32'h0);
    rd(3, wd, 32'hffff_ffff, 32'h1);
    st(32'h0000_0400);
    fr(29'h123, 1'b0, 1'b0, 64'hdead_beef_0000_0000);
    rd(0, wd, 32'hffff_ffff, 32'h1122_3344);
    chk({31'h0, receive_overrun_irq}, 32'h1);
    st(32'h0000_0400);
    apb(1'b1, ra(0, wc), 32'h0000_0028);
    fr(29'h123, 1'b0, 1'b0, 64'hdead_beef_0000_0000);
    rd(0, wd, 32'hffff_ffff, 32'hdead_beef);
    st(32'h0000_1000);
    $display("link test done");
    cfg(4, 32'h0000_0008, 32'h1, {29'h123_4567, 3'h4}, 16'hffff, 16'h0000);
    fr(29'h123_4567, 1'b1, 1'b0, 64'h0);
    rd(4, wc, 32'h0010_0001, 32'h0010_0001);
    rd(4, crf_pkg::W_ID, 32'hffff_fff8, {29'h123_4567, 3'h0});
    $display("extended test done");
    stall <= 1'b1;
    cfg(15, 32'h0000_0018, std_mask, 32'haaa0_0002, 16'hffff, 16'h0000);
    apb(1'b1, ra(15, wd), 32'hcafe_f00d);
    fr(29'h555, 1'b0, 1'b1, 64'h0);
    rd(15, wc, 32'h2, 32'h2);
    chk({31'h0, tx_valid}, 32'h1);
    chk({3'h0, tx_reply.id}, 32'h555);
    t0 = node.taken_ff;
    stall <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(32'(node.taken_ff - t0), 32'h1);
    chk({3'h0, node.last_ff.id}, 32'h555);
    chk(node.last_ff.data[63:32], 32'hcafe_f00d);
    rd(15, wc, 32'h2, 32'h0);
    stall <= 1'b1;
    // Cancel first, then disable, both while the far side stalls
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, ra(15, wc), 32'h0000_0018);
      fr(29'h555, 1'b0, 1'b1, 64'h0);
      rd(15, wc, 32'h2, 32'h2);
      apb(1'b1, ra(15, wc), (i == 0) ? 32'h0000_001c : 32'h0000_0010);
      rd(15, wc, 32'h2, 32'h0);
      chk({31'h0, tx_valid}, 32'h0);
    end
    // Remote frame into a plain buffer: software must answer it
    cfg(5, 32'h0000_0008, std_mask, 32'haaa0_0002, 16'hffff, 16'h0000);
    fr(29'h555, 1'b0, 1'b1, 64'h0);
    rd(5, wc, 32'h0020_0003, 32'h0020_0001);
    chk({31'h0, tx_valid}, 32'h0);
    $display("answer test done");
    apb(1'b0, 12'h204, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    chk(rdata, 32'h0);
    $display("unmapped test done");
    close_out();
  end
endmodule
